/* File: design/bulk_split_descriptor_decode.sv */
// Bulk/control descriptor store and field decoder
// Behaviour
// - Reload zero means NAK counter ignored
// - Hardware writes transferred byte count
// - Hub address targets split tokens
// - Port field selects hub port
// - Speed/end used only for splits
// - Split bit picks plain or split
// - Token picks OUT, IN or SETUP
// - Function address addresses the transaction
// - Endpoint number spans two words
// - Packets limited to maximum packet length
// - NAK counter exhausted clears valid bit
// - Completion or fatal error clears valid
//
// Local design decisions: the register offsets and the plain strobed port.
module bulk_split_descriptor_decode
	import bsd_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic txnDone,
	input wire logic [14:0] txnBytes,
	input wire logic txnNak,
	input wire logic txnFatal,
	input wire logic descComplete,
	output logic descActive,
	output logic splitMode,
	output logic [3:0] pidCode,
	output logic [6:0] hubTargetAddr,
	output logic [6:0] hubPortSelect,
	output logic [1:0] speedEndCode,
	output logic [1:0] endpointKind,
	output logic [6:0] functionAddr,
	output logic [3:0] endpointNumber,
	output logic [10:0] maxPacketBytes,
	output logic [10:0] packetBytes,
	output logic [15:0] bufferPointer,
	output logic [19:0] bufferCpuAddr,
	output logic [14:0] bytesRequestedCount,
	output logic [14:0] bytesDoneCount,
	output logic [3:0] nakCounter
);

	generate
		if (ADDR_W < 8)
		begin : gAddrCheck
			$error("ADDR_W must reach the word 3 offset");
		end
	endgenerate

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction : hit

	function automatic logic [3:0] pidOf(input logic [1:0] tok);
		unique case (tok)
			TOKEN_OUT: pidOf = PID_OUT;
			TOKEN_IN: pidOf = PID_IN;
			TOKEN_SETUP: pidOf = PID_SETUP;
			default: pidOf = PID_NONE;
		endcase
	endfunction : pidOf

	logic validR;
	logic epLsbR;
	logic [10:0] maxPktR;
	logic [14:0] bytesReqR;
	logic [31:0] dw1R;
	logic [3:0] reloadR;
	logic [15:0] bufPtrR;
	logic [14:0] bytesDoneR;
	logic [3:0] nakCntR;
	logic wrDw0;
	logic wrDw1;
	logic wrDw2;
	logic wrDw3;
	logic nakCounting;
	logic nakExhaust;
	logic [14:0] remaining;
	logic [31:0] rdNxt;

	assign wrDw0 = regWrite && hit(regAddr, OFS_DW0);
	assign wrDw1 = regWrite && hit(regAddr, OFS_DW1);
	assign wrDw2 = regWrite && hit(regAddr, OFS_DW2);
	assign wrDw3 = regWrite && hit(regAddr, OFS_DW3);

	// Counting only while the reload field is nonzero
	assign nakCounting = validR && txnNak && (reloadR != 4'h0);
	assign nakExhaust = nakCounting && (nakCntR <= 4'h1);

	// Word 0 fields; reserved bits are dropped on write
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			epLsbR <= 1'b0;
			maxPktR <= 11'h000;
			bytesReqR <= COUNT_RESET;
		end
		else if (wrDw0)
		begin
			epLsbR <= regWdata[EPLSB_POS];
			maxPktR <= regWdata[MPL_LSB +: 11];
			bytesReqR <= regWdata[REQ_LSB +: 15];
		end
	end

	// Software set wins over a hardware clear in the same cycle
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			validR <= 1'b0;
		end
		else if (wrDw0)
		begin
			validR <= regWdata[VALID_POS];
		end
		else if (validR && (descComplete || txnFatal))
		begin
			validR <= 1'b0;
		end
		else if (nakExhaust)
		begin
			validR <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dw1R <= DW1_RESET;
		end
		else if (wrDw1)
		begin
			dw1R <= regWdata & DW1_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reloadR <= NAK_RESET;
			bufPtrR <= PTR_RESET;
		end
		else if (wrDw2)
		begin
			reloadR <= regWdata[RELOAD_LSB +: 4];
			bufPtrR <= regWdata[BUFPTR_LSB +: 16];
		end
	end

	// Engine result wins so a finished count is never lost
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bytesDoneR <= COUNT_RESET;
		end
		else if (validR && txnDone)
		begin
			bytesDoneR <= txnBytes;
		end
		else if (wrDw3)
		begin
			bytesDoneR <= regWdata[DONE_LSB +: 15];
		end
	end

	// Progress reloads the counter; a NAK burns one count
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			nakCntR <= NAK_RESET;
		end
		else if (wrDw3)
		begin
			nakCntR <= regWdata[NAK_COUNTER_LSB +: 4];
		end
		else if (validR && txnDone && (reloadR != 4'h0))
		begin
			nakCntR <= reloadR;
		end
		else if (nakCounting && (nakCntR != 4'h0))
		begin
			nakCntR <= nakCntR - 4'h1;
		end
	end

	always_comb
	begin
		rdNxt = 32'h00000000;
		if (hit(regAddr, OFS_DW0))
		begin
			rdNxt[EPLSB_POS] = epLsbR;
			rdNxt[MPL_LSB +: 11] = maxPktR;
			rdNxt[REQ_LSB +: 15] = bytesReqR;
			rdNxt[VALID_POS] = validR;
		end
		else if (hit(regAddr, OFS_DW1))
		begin
			rdNxt = dw1R;
		end
		else if (hit(regAddr, OFS_DW2))
		begin
			rdNxt[RELOAD_LSB +: 4] = reloadR;
			rdNxt[BUFPTR_LSB +: 16] = bufPtrR;
		end
		else if (hit(regAddr, OFS_DW3))
		begin
			rdNxt[NAK_COUNTER_LSB +: 4] = nakCntR;
			rdNxt[DONE_LSB +: 15] = bytesDoneR;
		end
	end

	// Read data stands for one cycle only; unmapped reads give zero
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			regRdata <= 32'h00000000;
		end
		else if (regRead)
		begin
			regRdata <= rdNxt;
		end
		else
		begin
			regRdata <= 32'h00000000;
		end
	end

	// Floor at zero so an overrun engine count cannot wrap
	assign remaining = (bytesDoneR >= bytesReqR) ? 15'h0000 :
		15'(bytesReqR - bytesDoneR);

	// Decoded fields trail the stored words by one cycle
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			descActive <= 1'b0;
			splitMode <= 1'b0;
			pidCode <= PID_NONE;
			speedEndCode <= 2'h0;
		end
		else
		begin
			descActive <= validR;
			splitMode <= dw1R[SPLIT_POS];
			pidCode <= pidOf(dw1R[TOKEN_LSB +: 2]);
			// Plain high-speed transfers have no speed/end meaning
			speedEndCode <= dw1R[SPLIT_POS] ?
				dw1R[SPDEND_LSB +: 2] : 2'h0;
		end
	end

	// Routing fields, held as written
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hubTargetAddr <= 7'h00;
			hubPortSelect <= 7'h00;
			endpointKind <= 2'h0;
			functionAddr <= 7'h00;
			endpointNumber <= 4'h0;
		end
		else
		begin
			hubTargetAddr <= dw1R[HUB_LSB +: 7];
			hubPortSelect <= dw1R[PORT_LSB +: 7];
			endpointKind <= dw1R[KIND_LSB +: 2];
			functionAddr <= dw1R[FADDR_LSB +: 7];
			endpointNumber <= {dw1R[EPHI_LSB +: 3], epLsbR};
		end
	end

	// Length fields and the size of the next packet
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			maxPacketBytes <= 11'h000;
			packetBytes <= 11'h000;
			bytesRequestedCount <= COUNT_RESET;
		end
		else
		begin
			maxPacketBytes <= maxPktR;
			// No 64-byte clamp: full-speed limits are software's job
			packetBytes <= (remaining < {4'h0, maxPktR}) ?
				remaining[10:0] : maxPktR;
			bytesRequestedCount <= bytesReqR;
		end
	end

	// Engine-maintained counts as last stored
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bytesDoneCount <= COUNT_RESET;
			nakCounter <= NAK_RESET;
		end
		else
		begin
			bytesDoneCount <= bytesDoneR;
			nakCounter <= nakCntR;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bufferPointer <= PTR_RESET;
			bufferCpuAddr <= BUF_BASE;
		end
		else
		begin
			bufferPointer <= bufPtrR;
			bufferCpuAddr <= {1'b0, bufPtrR, 3'h0} + BUF_BASE;
		end
	end

endmodule : bulk_split_descriptor_decode

/* File: include/bsd_pkg.sv */
// Descriptor word offsets, field positions and constants
package bsd_pkg;
	localparam logic [7:0] OFS_DW0 = 8'h00;
	localparam logic [7:0] OFS_DW1 = 8'h04;
	localparam logic [7:0] OFS_DW2 = 8'h08;
	localparam logic [7:0] OFS_DW3 = 8'h0C;
	// Word 0
	localparam int VALID_POS = 0;
	localparam int REQ_LSB = 3;
	localparam int MPL_LSB = 18;
	localparam int EPLSB_POS = 31;
	// Word 1
	localparam int EPHI_LSB = 0;
	localparam int FADDR_LSB = 3;
	localparam int TOKEN_LSB = 10;
	localparam int KIND_LSB = 12;
	localparam int SPLIT_POS = 14;
	localparam int SPDEND_LSB = 16;
	localparam int PORT_LSB = 18;
	localparam int HUB_LSB = 25;
	localparam logic [31:0] DW1_MASK = 32'hFFFF7FFF;
	// Word 2
	localparam int BUFPTR_LSB = 8;
	localparam int RELOAD_LSB = 25;
	// Word 3
	localparam int DONE_LSB = 0;
	localparam int NAK_COUNTER_LSB = 19;
	// Reset values
	localparam logic [31:0] DW1_RESET = 32'h00000000;
	localparam logic [14:0] COUNT_RESET = 15'h0000;
	localparam logic [3:0] NAK_RESET = 4'h0;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	// Token codes and the packet identifiers they select
	localparam logic [1:0] TOKEN_OUT = 2'h0;
	localparam logic [1:0] TOKEN_IN = 2'h1;
	localparam logic [1:0] TOKEN_SETUP = 2'h2;
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hD;
	localparam logic [3:0] PID_NONE = 4'h0;
	// Buffer pointer: 8-byte units above this processor address
	localparam logic [19:0] BUF_BASE = 20'h00400;
endpackage : bsd_pkg

/* File: tb/bulk_split_descriptor_decode_assertions.sv */
// Port-level checks on the descriptor decoder
module bulk_split_descriptor_decode_assertions
	import bsd_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic txnDone,
	input wire logic [14:0] txnBytes,
	input wire logic descComplete,
	input wire logic descActive,
	input wire logic splitMode,
	input wire logic [6:0] hubTargetAddr,
	input wire logic [6:0] hubPortSelect,
	input wire logic [1:0] speedEndCode,
	input wire logic [15:0] bufferPointer,
	input wire logic [19:0] bufferCpuAddr,
	input wire logic [14:0] bytesDoneCount,
	input wire logic [3:0] nakCounter
);
	timeunit 1ns;
	timeprecision 1ps;
	logic zeroReload_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence dw1Wr;
		regWrite && regAddr == OFS_DW1;
	endsequence
	// Outcome counts only if the descriptor was valid when it came
	sequence doneWhileValid;
		txnDone ##1 descActive;
	endsequence
	// Shadow of the reload field, since it has no port of its own
	always_ff @(posedge ref_clk or negedge reset_n)
		if (!reset_n)
			zeroReload_r <= 1'b1;
		else if (regWrite && regAddr == OFS_DW2)
			zeroReload_r <= regWdata[28:25] == 4'h0;
	split_sel_a: assert property (
		dw1Wr |-> ##2 splitMode == $past(regWdata[14], 2)) else $error("split");
	hub_addr_a: assert property (
		dw1Wr |-> ##2 hubTargetAddr == $past(regWdata[31:25], 2))
		else $error("hub");
	port_sel_a: assert property (
		dw1Wr |-> ##2 hubPortSelect == $past(regWdata[24:18], 2))
		else $error("port");
	speed_end_a: assert property (
		!splitMode |-> speedEndCode == 2'h0) else $error("speed end");
	done_clear_a: assert property (
		descActive && descComplete && !(regWrite && regAddr == OFS_DW0)
		|-> ##2 !descActive) else $error("valid");
	nak_ignore_a: assert property (
		$past(zeroReload_r, 2) && !$past(regWrite, 2)
		|-> $stable(nakCounter)) else $error("nak counter");
	bytes_done_a: assert property (
		doneWhileValid |-> ##1 bytesDoneCount == $past(txnBytes, 2))
		else $error("bytes done");
	cpu_addr_a: assert property (
		bufferCpuAddr == {bufferPointer, 3'h0} + BUF_BASE) else $error("addr");
endmodule : bulk_split_descriptor_decode_assertions

bind bulk_split_descriptor_decode bulk_split_descriptor_decode_assertions
	#(.ADDR_W(ADDR_W)) CHK (
	.ref_clk(ref_clk),
	.reset_n(reset_n),
	.regAddr(regAddr),
	.regWdata(regWdata),
	.regWrite(regWrite),
	.txnDone(txnDone),
	.txnBytes(txnBytes),
	.descComplete(descComplete),
	.descActive(descActive),
	.splitMode(splitMode),
	.hubTargetAddr(hubTargetAddr),
	.hubPortSelect(hubPortSelect),
	.speedEndCode(speedEndCode),
	.bufferPointer(bufferPointer),
	.bufferCpuAddr(bufferCpuAddr),
	.bytesDoneCount(bytesDoneCount),
	.nakCounter(nakCounter)
);

/* File: tb/bulk_split_descriptor_decode_tb.sv */
// Self-checking bench for the descriptor decoder
module bulk_split_descriptor_decode_tb import bsd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = '0, reset_n = '0, regWrite = '0, regRead = '0;
	logic [7:0] regAddr = '0;
	logic [31:0] regWdata = '0, regRdata, got;
	logic txnDone, txnNak, txnFatal, descComplete, descActive, splitMode;
	logic [14:0] txnBytes, bytesRequestedCount, bytesDoneCount;
	logic [3:0] pidCode, endpointNumber, nakCounter;
	logic [6:0] hubTargetAddr, hubPortSelect, functionAddr;
	logic [1:0] speedEndCode, endpointKind;
	logic [10:0] maxPacketBytes, packetBytes;
	logic [15:0] bufferPointer;
	logic [19:0] bufferCpuAddr;
	int errors = 0, checks_done = 0;
	bulk_split_descriptor_decode DUT (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWrite(regWrite),
		.regRead(regRead),
		.regRdata(regRdata),
		.txnDone(txnDone),
		.txnBytes(txnBytes),
		.txnNak(txnNak),
		.txnFatal(txnFatal),
		.descComplete(descComplete),
		.descActive(descActive),
		.splitMode(splitMode),
		.pidCode(pidCode),
		.hubTargetAddr(hubTargetAddr),
		.hubPortSelect(hubPortSelect),
		.speedEndCode(speedEndCode),
		.endpointKind(endpointKind),
		.functionAddr(functionAddr),
		.endpointNumber(endpointNumber),
		.maxPacketBytes(maxPacketBytes),
		.packetBytes(packetBytes),
		.bufferPointer(bufferPointer),
		.bufferCpuAddr(bufferCpuAddr),
		.bytesRequestedCount(bytesRequestedCount),
		.bytesDoneCount(bytesDoneCount),
		.nakCounter(nakCounter)
	);
	txn_engine_model ENG (
		.ref_clk(ref_clk),
		.txnDone(txnDone),
		.txnBytes(txnBytes),
		.txnNak(txnNak),
		.txnFatal(txnFatal),
		.descComplete(descComplete)
	);
	always #10 ref_clk = ~ref_clk;
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 got = regRdata;
	endtask : rd
	// Decoded outputs trail a write by two edges
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic t_fields;
		chk("cpuAddr", 32'h400, bufferCpuAddr);
		wr(OFS_DW1, 32'hFF574555);
		wr(OFS_DW0, 32'h80000000);
		settle;
		chk("hub", 32'h7F, hubTargetAddr);
		chk("port", 32'h55, hubPortSelect);
		chk("func", 32'h2A, functionAddr);
		chk("speedEnd", 32'h3, speedEndCode);
		chk("endpoint", 32'hB, endpointNumber);
		chk("split", 32'h1, splitMode);
	endtask : t_fields
	task automatic t_tokens;
		logic [3:0] pid [4] = '{PID_OUT, PID_IN, PID_SETUP, PID_NONE};
		for (int t = 0; t < 4; t++)
		begin
			wr(OFS_DW1, 32'h00032000 | (t << 10));
			settle;
			chk("pid", pid[t], pidCode);
			chk("speedEnd", 32'h0, speedEndCode);
			chk("kind", 32'h2, endpointKind);
		end
		wr(OFS_DW2, 32'hFFFFFFFF);
		rd(OFS_DW2);
		chk("word2", 32'h1EFFFF00, got);
		wr(OFS_DW1, 32'hFFFFBFFF);
		rd(OFS_DW1);
		chk("word1", 32'hFFFF3FFF, got);
		rd(8'h10);
		chk("unmapped", 32'h0, got);
		settle;
		chk("cpuAddr", 32'h803F8, bufferCpuAddr);
		chk("pointer", 32'hFFFF, bufferPointer);
	endtask : t_tokens
	task automatic t_nak;
		wr(OFS_DW2, 32'h06000000);
		wr(OFS_DW3, 32'h00180000);
		wr(OFS_DW0, 32'h01000321);
		settle;
		chk("packet", 32'h40, packetBytes);
		chk("maxPacket", 32'h40, maxPacketBytes);
		chk("requested", 32'h64, bytesRequestedCount);
		repeat (2) ENG.pulse(1, 15'h0);
		settle;
		chk("nakCount", 32'h1, nakCounter);
		chk("active", 32'h1, descActive);
		ENG.pulse(1, 15'h0);
		settle;
		chk("active", 32'h0, descActive);
	endtask : t_nak
	task automatic t_reload0;
		wr(OFS_DW2, 32'h0);
		wr(OFS_DW3, 32'h00280000);
		wr(OFS_DW0, 32'h01000321);
		repeat (3) ENG.pulse(1, 15'h0);
		ENG.pulse(0, 15'h0028);
		settle;
		chk("nakCount", 32'h5, nakCounter);
		chk("active", 32'h1, descActive);
		chk("done", 32'h28, bytesDoneCount);
		chk("packet", 32'h3C, packetBytes);
		rd(OFS_DW3);
		chk("word3", 32'h00280028, got);
		ENG.pulse(3, 15'h0);
		settle;
		chk("active", 32'h0, descActive);
		wr(OFS_DW0, 32'h01000321);
		settle;
		chk("active", 32'h1, descActive);
		ENG.pulse(2, 15'h0);
		settle;
		chk("active", 32'h0, descActive);
	endtask : t_reload0
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_fields;
		t_tokens;
		t_nak;
		t_reload0;
		print_verdict;
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		print_verdict;
	end
endmodule : bulk_split_descriptor_decode_tb

/* File: tb/txn_engine_model.sv */
// Transfer engine stand-in that reports outcomes
module txn_engine_model
(
	input wire logic ref_clk,
	output logic txnDone,
	output logic [14:0] txnBytes,
	output logic txnNak,
	output logic txnFatal,
	output logic descComplete
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {txnDone, txnBytes, txnNak, txnFatal, descComplete} = '0;
	// One-cycle outcome: 0 done, 1 NAK, 2 fatal, 3 complete
	task automatic pulse(input int k, input logic [14:0] n);
		@(posedge ref_clk);
		txnDone <= k == 0;
		txnNak <= k == 1;
		txnFatal <= k == 2;
		descComplete <= k == 3;
		txnBytes <= n;
		@(posedge ref_clk);
		{txnDone, txnNak, txnFatal, descComplete} <= '0;
		// Count no longer held, so show a stale-looking value
		txnBytes <= ~n;
	endtask : pulse
endmodule : txn_engine_model
